// ===== src/chopper_consts.svh
`ifndef CHOPPER_CONSTS_SVH
`define CHOPPER_CONSTS_SVH

// Register byte offsets on the APB port
`define ADDR_CTRL 8'h00
`define ADDR_THRESHOLD 8'h04
`define ADDR_DELAYS 8'h08
`define ADDR_STEP_INTERVAL 8'h0c
`define ADDR_AMPLITUDE 8'h10
`define ADDR_STATUS 8'h14
`define ADDR_IRQ_STATUS 8'h18
`define ADDR_IRQ_MASK 8'h1c

// Control register fields
`define CTRL_VOLT_EN 0
`define CTRL_PHASE_EN 1
`define CTRL_OPT_LO 2
`define CTRL_OPT_HI 3
`define CTRL_RANGE_LO 4
`define CTRL_RANGE_HI 5
`define CTRL_HOLD_LO 8
`define CTRL_HOLD_HI 12
`define CTRL_RESET 32'h0000_0000

// Delay register fields, both counted in chopper periods
`define DLY_PD_LO 0
`define DLY_PD_HI 7
`define DLY_HR_LO 8
`define DLY_HR_HI 11

// Interrupt status bits
`define IRQ_MODE 0
`define IRQ_OPEN 1
`define IRQ_SAT 2

// Widths, limits and timing
`define THR_MAX 20'hfffff
`define THR_RESET 20'h00000
`define AMP_MAX 10'h3ff
`define AMP_RESET 10'h000
`define PERIOD_LAST 9'h1ff
`define OL_FULLSTEPS 2'h3
`define PARK_TIMER_MAX 9'h1ff
`define RANGE_LOW 2'h0
`define RANGE_MID 2'h1

`endif

// ===== src/chopper_pkg.sv
package chopper_pkg;

    // ==========================================================
    // Chopper mode states, Gray coded along the usual path
    typedef enum logic [1:0]
    {
        MODE_VOLT = 2'h0,
        MODE_CURR = 2'h1,
        MODE_PARK = 2'h2
    } chop_mode_t;

    typedef logic [9:0] amp_t;

    // One saturating regulation step of the amplitude
    function automatic amp_t amp_step(input amp_t v, input logic up);
        begin
            if (up)
            begin
                amp_step = (v == 10'h3ff) ? v : amp_t'(v + 10'h001);
            end
            else
            begin
                amp_step = (v == 10'h000) ? v : amp_t'(v - 10'h001);
            end
        end
    endfunction : amp_step

endpackage : chopper_pkg

// ===== src/pwm_regulator.sv
`timescale 1ns/100ps
`include "chopper_consts.svh"

module pwm_regulator
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic raise,
    output logic [9:0] amp
);

    // ==========================================================
    // Regulation state: moves only on run, otherwise it is held
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            amp <= `AMP_RESET;
        else if (ce && run)
            amp <= chopper_pkg::amp_step(amp, raise);
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_hold_when_idle: assert property (!(ce && run) |=> $stable(amp))
        else $error("Regulation state moved while idle");
    chk_amp_saturate: assert property (ce && run && raise && amp == `AMP_MAX |=> amp == `AMP_MAX)
        else $error("Amplitude wrapped past its limit");

endmodule : pwm_regulator

// ===== src/chopper_mode_switch.sv
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/100ps
`include "chopper_consts.svh"

// What this block does
// - Voltage chopper at low speed; current chopper above programmed velocity threshold.
// - Threshold zero keeps the block in voltage mode for good while voltage enable is set.
// - Voltage regulation value is kept during current mode and resumed.
// - With offset enabled, measured phase shift is applied during current mode entered above a nonzero threshold.
// - Open-load flags set when target not reached in recent fullsteps.
// - Summed amplitude readable, saturating at 1023, meaning current not sustained.
// - Zero hold current applies standstill option after power-down and ramp delays.
// - Regulation state frozen while target current is zero.
// - Overcurrent level follows drive range in three steps.
// - Voltage mode off while step interval below threshold; threshold is 20 bits.
// - Global enable clear forces current mode regardless of threshold.

module chopper_mode_switch
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic STEP_PULSE,
    input wire logic FULLSTEP,
    input wire logic [7:0] LOAD_ANGLE,
    input wire logic CUR_LOW_A,
    input wire logic CUR_LOW_B,
    output logic CURRENT_MODE,
    output logic [7:0] PHASE_SHIFT,
    output logic [1:0] STANDSTILL_MODE,
    output logic [1:0] OCP_LEVEL,
    output logic [9:0] PWM_AMPLITUDE,
    output logic IRQ
);

    // ==========================================================
    // Registers and state
    logic [31:0] ctrl;
    logic [19:0] voltage_mode_velocity_threshold;
    logic [11:0] delays;
    logic [19:0] measured_step_interval;
    logic [19:0] step_cnt;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic [8:0] period_cnt;
    logic [8:0] park_timer;
    logic [1:0] ol_cnt_a;
    logic [1:0] ol_cnt_b;
    logic reached_a;
    logic reached_b;
    logic open_load_coil_a;
    logic open_load_coil_b;
    logic pending_eval;
    logic sync_a1, sync_a2, sync_b1, sync_b2;
    logic amp_was_max;
    chopper_pkg::chop_mode_t mode;
    chopper_pkg::chop_mode_t next_mode;
    logic [9:0] pwm_amplitude_sum;

    // ==========================================================
    // Control fields
    wire voltage_enable = ctrl[`CTRL_VOLT_EN];
    wire phase_offset_enable = ctrl[`CTRL_PHASE_EN];
    wire [1:0] standstill_option_select = ctrl[`CTRL_OPT_HI:`CTRL_OPT_LO];
    wire [1:0] drive_current_range = ctrl[`CTRL_RANGE_HI:`CTRL_RANGE_LO];
    wire [4:0] hold_current_setting = ctrl[`CTRL_HOLD_HI:`CTRL_HOLD_LO];
    wire [7:0] power_down_delay = delays[`DLY_PD_HI:`DLY_PD_LO];
    wire [3:0] hold_ramp_delay = delays[`DLY_HR_HI:`DLY_HR_LO];

    // ==========================================================
    // APB decode; one wait state so that read data come from a register
    wire apb_access = PSEL && PENABLE;
    wire apb_done = apb_access && PREADY;
    wire apb_wr = apb_done && PWRITE;
    wire apb_rd = apb_done && !PWRITE;
    wire hit_ctrl = (PADDR == `ADDR_CTRL);
    wire hit_thr = (PADDR == `ADDR_THRESHOLD);
    wire hit_dly = (PADDR == `ADDR_DELAYS);
    wire hit_irq_st = (PADDR == `ADDR_IRQ_STATUS);
    wire hit_mask = (PADDR == `ADDR_IRQ_MASK);
    wire mapped = hit_ctrl || hit_thr || hit_dly || hit_irq_st || hit_mask ||
        (PADDR == `ADDR_STEP_INTERVAL) || (PADDR == `ADDR_AMPLITUDE) || (PADDR == `ADDR_STATUS);
    wire in_curr = (mode == chopper_pkg::MODE_CURR);
    wire in_volt = (mode == chopper_pkg::MODE_VOLT);
    wire in_park = (mode == chopper_pkg::MODE_PARK);

    // Read multiplexer; unmapped addresses read zero
    wire [31:0] rd_mux =
        hit_ctrl ? ctrl :
        hit_thr ? {12'h000, voltage_mode_velocity_threshold} :
        hit_dly ? {20'h00000, delays} :
        (PADDR == `ADDR_STEP_INTERVAL) ? {12'h000, measured_step_interval} :
        (PADDR == `ADDR_AMPLITUDE) ? {8'h00, PHASE_SHIFT, 6'h00, pwm_amplitude_sum} :
        (PADDR == `ADDR_STATUS) ? {28'h0000000, in_park, open_load_coil_b, open_load_coil_a, in_curr} :
        hit_irq_st ? {29'h00000000, irq_status} :
        hit_mask ? {29'h00000000, irq_mask} : 32'h0000_0000;

    // Bus answer: ready one cycle into the access phase
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end
        else if (CLK_EN)
        begin
            PREADY <= apb_access && !PREADY;
            PRDATA <= rd_mux;
            PSLVERR <= apb_access && !PREADY && !mapped;
        end
    end

    // Software-written registers
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl <= `CTRL_RESET;
            voltage_mode_velocity_threshold <= `THR_RESET;
            delays <= 12'h000;
            irq_mask <= 3'h0;
        end
        else if (CLK_EN && apb_wr)
        begin
            if (hit_ctrl)
                ctrl <= {19'h00000, PWDATA[`CTRL_HOLD_HI:`CTRL_HOLD_LO], 2'h0, PWDATA[5:0]};
            if (hit_thr)
                voltage_mode_velocity_threshold <= PWDATA[19:0];
            if (hit_dly)
                delays <= PWDATA[11:0];
            if (hit_mask)
                irq_mask <= PWDATA[2:0];
        end
    end

    // ==========================================================
    // Coil comparator pins pass a two-stage synchroniser
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            {sync_a1, sync_a2, sync_b1, sync_b2} <= 4'h0;
        else if (CLK_EN)
            {sync_a1, sync_a2, sync_b1, sync_b2} <= {CUR_LOW_A, sync_a1, CUR_LOW_B, sync_b1};
    end

    // ==========================================================
    // Chopper period and step interval measurement
    wire period_tick = (period_cnt == `PERIOD_LAST);
    wire step_sat = (step_cnt == `THR_MAX);
    wire new_meas = STEP_PULSE || (step_cnt == (`THR_MAX - 20'h00001));

    // A stopped motor shows the full interval so the threshold compare stays sane
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            period_cnt <= 9'h000;
            step_cnt <= 20'h00000;
            measured_step_interval <= `THR_MAX;
        end
        else if (CLK_EN)
        begin
            period_cnt <= period_tick ? 9'h000 : period_cnt + 9'h001;
            step_cnt <= STEP_PULSE ? 20'h00000 : (step_sat ? step_cnt : step_cnt + 20'h00001);
            if (new_meas)
                measured_step_interval <= STEP_PULSE ? step_cnt : `THR_MAX;
        end
    end

    // ==========================================================
    // Mode selection
    wire thr_active = (voltage_mode_velocity_threshold != `THR_RESET);
    wire fast = thr_active && (measured_step_interval < voltage_mode_velocity_threshold);
    wire want_curr = !voltage_enable || fast;
    wire cfg_write = apb_wr && (hit_ctrl || hit_thr);
    wire evaluate = period_tick && pending_eval;
    wire park_due = (park_timer >= ({1'b0, power_down_delay} + {5'h00, hold_ramp_delay}));
    wire park_ok = (hold_current_setting == 5'h00) && park_due;

    // A new measurement arriving with the boundary keeps the flag set
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            pending_eval <= 1'b1;
        else if (CLK_EN)
            pending_eval <= new_meas || cfg_write || (pending_eval && !period_tick);
    end

    // Next mode, applied on a chopper period boundary, except that a step, a lost park condition or want_curr leaves park at once
    always_comb
    begin
        next_mode = mode;
        case (mode)
            chopper_pkg::MODE_VOLT:
            begin
                if (evaluate && want_curr)
                    next_mode = chopper_pkg::MODE_CURR;
                else if (period_tick && park_ok)
                    next_mode = chopper_pkg::MODE_PARK;
            end
            chopper_pkg::MODE_CURR:
            begin
                if (evaluate && !want_curr)
                    next_mode = chopper_pkg::MODE_VOLT;
            end
            chopper_pkg::MODE_PARK:
            begin
                if (STEP_PULSE || !park_ok || want_curr)
                    next_mode = chopper_pkg::MODE_VOLT;
            end
            default:
                next_mode = chopper_pkg::MODE_VOLT;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            mode <= chopper_pkg::MODE_VOLT;
        else if (CLK_EN)
            mode <= next_mode;
    end

    // ==========================================================
    // Standstill timer in chopper periods since the last step
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
            park_timer <= 9'h000;
        else if (CLK_EN)
        begin
            if (STEP_PULSE)
                park_timer <= 9'h000;
            else if (period_tick && park_timer != `PARK_TIMER_MAX)
                park_timer <= park_timer + 9'h001;
        end
    end

    // ==========================================================
    // Voltage regulation; held in current mode and while target is zero
    wire reg_run = in_volt && period_tick;
    wire reg_raise = sync_a2 || sync_b2;

    pwm_regulator u_regulator
    (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .ce(CLK_EN),
        .run(reg_run),
        .raise(reg_raise),
        .amp(pwm_amplitude_sum)
    );

    // ==========================================================
    // Open-load tracking per coil, counted in fullsteps, voltage mode only
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            {reached_a, reached_b} <= 2'h0;
            ol_cnt_a <= 2'h0;
            ol_cnt_b <= 2'h0;
        end
        else if (CLK_EN && in_volt)
        begin
            if (FULLSTEP)
            begin
                ol_cnt_a <= reached_a ? 2'h0 : (ol_cnt_a == `OL_FULLSTEPS ? ol_cnt_a : ol_cnt_a + 2'h1);
                ol_cnt_b <= reached_b ? 2'h0 : (ol_cnt_b == `OL_FULLSTEPS ? ol_cnt_b : ol_cnt_b + 2'h1);
                {reached_a, reached_b} <= 2'h0;
            end
            else if (period_tick)
            begin
                reached_a <= reached_a || !sync_a2;
                reached_b <= reached_b || !sync_b2;
            end
        end
    end

    assign open_load_coil_a = (ol_cnt_a == `OL_FULLSTEPS);
    assign open_load_coil_b = (ol_cnt_b == `OL_FULLSTEPS);

    // ==========================================================
    // Interrupt status: sticky, cleared by reading, a new event wins
    wire amp_at_max = (pwm_amplitude_sum == `AMP_MAX);
    wire [2:0] irq_event;
    assign irq_event[`IRQ_MODE] = (next_mode == chopper_pkg::MODE_CURR) != in_curr;
    assign irq_event[`IRQ_OPEN] = FULLSTEP && in_volt &&
        ((!reached_a && ol_cnt_a == 2'h2) || (!reached_b && ol_cnt_b == 2'h2));
    assign irq_event[`IRQ_SAT] = amp_at_max && !amp_was_max;
    wire irq_clear = apb_rd && hit_irq_st;

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            irq_status <= 3'h0;
            amp_was_max <= 1'b0;
            IRQ <= 1'b0;
        end
        else if (CLK_EN)
        begin
            irq_status <= irq_event | (irq_clear ? 3'h0 : irq_status);
            amp_was_max <= amp_at_max;
            IRQ <= |(irq_mask & (irq_event | (irq_clear ? 3'h0 : irq_status)));
        end
    end

    // ==========================================================
    // Outputs toward the drive stage
    wire [1:0] ocp_sel = (drive_current_range == `RANGE_LOW) ? 2'h0 :
        (drive_current_range == `RANGE_MID) ? 2'h1 : 2'h2;
    wire entering_curr = (next_mode == chopper_pkg::MODE_CURR) && !in_curr;
    wire angle_on = phase_offset_enable && thr_active && voltage_enable;

    // Phase offset captured at the switch, dropped on the way back
    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            CURRENT_MODE <= 1'b0;
            PHASE_SHIFT <= 8'h00;
            STANDSTILL_MODE <= 2'h0;
            OCP_LEVEL <= 2'h0;
            PWM_AMPLITUDE <= `AMP_RESET;
        end
        else if (CLK_EN)
        begin
            CURRENT_MODE <= (next_mode == chopper_pkg::MODE_CURR);
            if (entering_curr)
                PHASE_SHIFT <= angle_on ? LOAD_ANGLE : 8'h00;
            else if (next_mode != chopper_pkg::MODE_CURR)
                PHASE_SHIFT <= 8'h00;
            STANDSTILL_MODE <= (next_mode == chopper_pkg::MODE_PARK) ? standstill_option_select : 2'h0;
            OCP_LEVEL <= ocp_sel;
            PWM_AMPLITUDE <= pwm_amplitude_sum;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    chk_change_on_boundary: assert property ($changed(CURRENT_MODE) |-> $past(CLK_EN && period_tick))
        else $error("Chopper mode changed off a period boundary");
    chk_curr_only_fast: assert property (CLK_EN && in_volt && next_mode == chopper_pkg::MODE_CURR
        |-> period_tick && want_curr)
        else $error("Current mode entered off boundary or below speed");
    chk_zero_thr_volt: assert property (CLK_EN && voltage_enable && !thr_active && evaluate |=> !in_curr)
        else $error("Zero threshold still allows current mode");
    chk_global_off_curr: assert property (CLK_EN && !voltage_enable && evaluate |=> in_curr)
        else $error("Global disable did not force current mode");
    chk_slow_returns_volt: assert property (CLK_EN && in_curr && evaluate && !want_curr
        |=> in_volt && !CURRENT_MODE)
        else $error("Slow interval did not restore voltage mode");
    chk_phase_capture: assert property (CLK_EN && entering_curr && angle_on
        |=> PHASE_SHIFT == $past(LOAD_ANGLE))
        else $error("Phase offset not taken at switch");
    chk_regulation_frozen: assert property ((in_park || in_curr) && period_tick
        |=> $stable(pwm_amplitude_sum))
        else $error("Regulation ran with zero target or in current mode");
    chk_open_load_clear: assert property (CLK_EN && in_volt && FULLSTEP && reached_a && reached_b
        |=> !open_load_coil_a && !open_load_coil_b)
        else $error("Open-load flag kept while current reached");
    chk_park_after_delay: assert property (STANDSTILL_MODE != 2'h0 |-> $past(park_ok))
        else $error("Standstill option applied too early");
    chk_ocp_range: assert property (CLK_EN && drive_current_range[1] |=> OCP_LEVEL == 2'h2)
        else $error("Overcurrent level does not follow range");

    cov_to_current: cover property (in_volt ##1 in_curr);
    cov_back_to_volt: cover property (in_curr ##1 in_volt);
    cov_park: cover property (in_volt ##1 in_park);
    cov_amp_limit: cover property ($rose(amp_at_max));

endmodule : chopper_mode_switch

// ===== tb/coil_model.sv
`timescale 1ns/100ps

// ==========================================================
// Two coils behind the bridges, as the comparators see them
module coil_model
#(
    parameter logic [9:0] NEED = 10'h010,
    parameter logic [7:0] ANGLE = 8'h5a
)
(
    input wire logic [9:0] amp,
    input wire logic open_a,
    output logic cur_low_a,
    output logic cur_low_b,
    output logic [7:0] load_angle
);
    // A broken coil never reaches target; a whole one needs NEED of amplitude
    assign cur_low_a = open_a | (amp < NEED);
    assign cur_low_b = amp < NEED;
    // Load detector reports a fixed phase shift, enough to spot it at the port
    assign load_angle = ANGLE;
endmodule : coil_model

// ===== tb/chopper_mode_switch_standstill_bench.sv
`timescale 1ns/100ps
`include "chopper_consts.svh"

module chopper_mode_switch_standstill_bench;
    logic CORE_CLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, CURRENT_MODE;
    logic STEP_PULSE, FULLSTEP, CUR_LOW_A, CUR_LOW_B, open_a, err;
    logic [7:0] PADDR, LOAD_ANGLE, PHASE_SHIFT;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [1:0] STANDSTILL_MODE, OCP_LEVEL;
    logic [1:0] fs_cnt = 2'h0;
    logic [9:0] PWM_AMPLITUDE, amp_c;
    int fails, comparisons, step_gap, gap_cnt, cycles;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} row_t;
    row_t rows[16];

    chopper_mode_switch uut
    (
        .CORE_CLK(CORE_CLK), .RST_N(RST_N), .CLK_EN(1'h1), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .STEP_PULSE(STEP_PULSE), .FULLSTEP(FULLSTEP), .LOAD_ANGLE(LOAD_ANGLE),
        .CUR_LOW_A(CUR_LOW_A), .CUR_LOW_B(CUR_LOW_B), .CURRENT_MODE(CURRENT_MODE),
        .PHASE_SHIFT(PHASE_SHIFT), .STANDSTILL_MODE(STANDSTILL_MODE), .OCP_LEVEL(OCP_LEVEL),
        .PWM_AMPLITUDE(PWM_AMPLITUDE), .IRQ(IRQ)
    );

    coil_model coils
    (
        .amp(PWM_AMPLITUDE), .open_a(open_a), .cur_low_a(CUR_LOW_A), .cur_low_b(CUR_LOW_B),
        .load_angle(LOAD_ANGLE)
    );

    // ==========================================================
    // Clock, step source and hang guard
    initial
    begin
        CORE_CLK = 1'h0;
        forever #50 CORE_CLK = ~CORE_CLK;
    end

    // Every fourth microstep is a fullstep, so at a gap of 300 each fullstep spans more than two periods
    always @(posedge CORE_CLK)
    begin
        gap_cnt <= (step_gap != 0 && gap_cnt + 1 < step_gap) ? gap_cnt + 1 : 0;
        STEP_PULSE <= step_gap != 0 && gap_cnt + 1 >= step_gap;
        FULLSTEP <= step_gap != 0 && gap_cnt + 1 >= step_gap && fs_cnt == 2'h3;
        if (step_gap != 0 && gap_cnt + 1 >= step_gap)
            fs_cnt <= fs_cnt + 2'h1;
        cycles <= cycles + 1;
        if (cycles == 95000)
        begin
            fails = fails + 1;
            $display("MISMATCH %0t run hung", $time);
            give_verdict();
        end
    end

    // ==========================================================
    // Shared tasks
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("MISMATCH %0t %s got %h want %h", $time, what, got, exp);
        end
    end
    endtask : check

    // One APB transfer; answer taken at the rising edge where PREADY is sampled high, then released
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    begin
        PSEL <= 1'h1;
        PENABLE <= 1'h0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CORE_CLK);
        PENABLE <= 1'h1;
        // Only the bench timeout ends a wait that never gets an answer
        do
            @(posedge CORE_CLK);
        while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        check({31'h0, PREADY}, 32'h1, "bus answer");
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CORE_CLK);
    end
    endtask : apb

    // Mode only moves at a period boundary, so the waits are bounded by periods
    task wait_mode(input logic want, input int lim);
        int n;
    begin
        n = 0;
        while (CURRENT_MODE !== want && n < lim)
        begin
            @(posedge CORE_CLK);
            n = n + 1;
        end
        check({31'h0, CURRENT_MODE}, {31'h0, want}, "mode");
    end
    endtask : wait_mode

    task do_reset;
    begin
        RST_N <= 1'h0;
        repeat (4) @(posedge CORE_CLK);
        RST_N <= 1'h1;
        @(posedge CORE_CLK);
    end
    endtask : do_reset

    task give_verdict;
    begin
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask : give_verdict

    // ==========================================================
    // Main sequence
    initial
    begin
        RST_N = 1'h0;
        {PSEL, PENABLE, PWRITE, open_a} = 4'h0;
        PADDR = 8'h0;
        PWDATA = 32'h0;
        rows = '{'{`ADDR_CTRL, 1'h0, 32'h0, 32'h0, 1'h0}, '{`ADDR_STEP_INTERVAL, 1'h0, 32'h0, 32'hfffff, 1'h0},
            '{`ADDR_THRESHOLD, 1'h1, 32'hfff12345, 32'h0, 1'h0}, '{`ADDR_THRESHOLD, 1'h0, 32'h0, 32'h12345, 1'h0},
            '{`ADDR_THRESHOLD, 1'h1, 32'hfffff, 32'h0, 1'h0}, '{`ADDR_THRESHOLD, 1'h0, 32'h0, 32'hfffff, 1'h0},
            '{`ADDR_STEP_INTERVAL, 1'h1, 32'h0, 32'h0, 1'h0}, '{`ADDR_STEP_INTERVAL, 1'h0, 32'h0, 32'hfffff, 1'h0},
            '{`ADDR_DELAYS, 1'h1, 32'hfffffa21, 32'h0, 1'h0}, '{`ADDR_DELAYS, 1'h0, 32'h0, 32'ha21, 1'h0},
            '{`ADDR_IRQ_MASK, 1'h1, 32'hff, 32'h0, 1'h0}, '{`ADDR_IRQ_MASK, 1'h0, 32'h0, 32'h7, 1'h0},
            '{8'h20, 1'h0, 32'h0, 32'h0, 1'h1}, '{8'h20, 1'h1, 32'h1, 32'h0, 1'h1},
            '{`ADDR_CTRL, 1'h1, 32'hffffffff, 32'h0, 1'h0}, '{`ADDR_CTRL, 1'h0, 32'h0, 32'h1f3f, 1'h0}};
        do_reset();
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w)
                check(rd, rows[i].x, "register read");
            check({31'h0, err}, {31'h0, rows[i].e}, "slave error");
        end
        $display("test registers done");
        // A second reset mid-run must bring the threshold back to zero
        do_reset();
        apb(`ADDR_THRESHOLD, 1'h0, 32'h0);
        check(rd, 32'h0, "threshold after reset");
        apb(`ADDR_IRQ_MASK, 1'h1, 32'h1);
        wait_mode(1'h1, 1100);
        repeat (2) @(posedge CORE_CLK);
        check({31'h0, IRQ}, 32'h1, "irq raised");
        apb(`ADDR_IRQ_STATUS, 1'h0, 32'h0);
        check(rd & 32'h1, 32'h1, "mode change event");
        repeat (2) @(posedge CORE_CLK);
        check({31'h0, IRQ}, 32'h0, "irq cleared by read");
        for (int r = 0; r < 4; r++)
        begin
            apb(`ADDR_CTRL, 1'h1, 32'h100 | (r << 4));
            repeat (2) @(posedge CORE_CLK);
            check({30'h0, OCP_LEVEL}, (r == 3) ? 32'h2 : r, "overcurrent level");
        end
        $display("test enable and range done");
        // Zero threshold: voltage mode for good, with the mode interrupt masked
        apb(`ADDR_IRQ_MASK, 1'h1, 32'h0);
        apb(`ADDR_CTRL, 1'h1, 32'h101);
        wait_mode(1'h0, 1100);
        // Motor kept still for 128 chopper periods after voltage mode is first enabled
        repeat (65536) @(posedge CORE_CLK);
        check({31'h0, CURRENT_MODE}, 32'h0, "still voltage");
        check({31'h0, IRQ}, 32'h0, "masked irq");
        apb(`ADDR_IRQ_STATUS, 1'h0, 32'h0);
        check(rd & 32'h1, 32'h1, "masked event kept");
        step_gap <= 300; // Flags cleared, motion restarts from zero speed
        repeat (1200) @(posedge CORE_CLK);
        apb(`ADDR_STATUS, 1'h0, 32'h0);
        check(rd & 32'h6, 32'h0, "open load clear");
        open_a <= 1'h1;
        repeat (5000) @(posedge CORE_CLK);
        apb(`ADDR_STATUS, 1'h0, 32'h0);
        check(rd & 32'h2, 32'h2, "open load set");
        open_a <= 1'h0;
        repeat (6000) @(posedge CORE_CLK);
        apb(`ADDR_STATUS, 1'h0, 32'h0);
        check(rd & 32'h2, 32'h0, "open load gone");
        $display("test voltage only done");
        // Threshold written while still in voltage mode
        apb(`ADDR_THRESHOLD, 1'h1, 32'h64);
        apb(`ADDR_CTRL, 1'h1, 32'h103);
        step_gap <= 10;
        wait_mode(1'h1, 1600);
        check({24'h0, PHASE_SHIFT}, 32'h5a, "phase shift applied");
        repeat (4) @(posedge CORE_CLK);
        amp_c = PWM_AMPLITUDE;
        repeat (2000) @(posedge CORE_CLK);
        check({22'h0, PWM_AMPLITUDE}, {22'h0, amp_c}, "value kept in current mode");
        step_gap <= 300;
        wait_mode(1'h0, 2000);
        check({24'h0, PHASE_SHIFT}, 32'h0, "phase shift dropped");
        check({31'h0, PWM_AMPLITUDE + 10'h1 - amp_c <= 10'h2}, 32'h1, "resumed from kept value");
        $display("test threshold switching done");
        // Standstill: both delays one period, option two, hold current zero
        apb(`ADDR_DELAYS, 1'h1, 32'h101);
        apb(`ADDR_CTRL, 1'h1, 32'h9);
        step_gap <= 0;
        repeat (400) @(posedge CORE_CLK);
        check({30'h0, STANDSTILL_MODE}, 32'h0, "not parked before delays");
        for (int n = 0; n < 3000 && STANDSTILL_MODE !== 2'h2; n++)
            @(posedge CORE_CLK);
        check({30'h0, STANDSTILL_MODE}, 32'h2, "standstill option");
        // The last regulation step reaches the output one cycle after parking
        @(posedge CORE_CLK);
        amp_c = PWM_AMPLITUDE;
        repeat (1600) @(posedge CORE_CLK);
        check({22'h0, PWM_AMPLITUDE}, {22'h0, amp_c}, "frozen while parked");
        step_gap <= 300;
        repeat (700) @(posedge CORE_CLK);
        check({30'h0, STANDSTILL_MODE}, 32'h0, "step leaves standstill");
        $display("test standstill done");
        give_verdict();
    end
endmodule : chopper_mode_switch_standstill_bench
